/* File: logic/vsd_pkg.sv */
// Shared constants and types for the display serial input and sync block.
package vsd_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int SHIFT_W = 48;
  localparam int DIM_W = 10;
  localparam int SEG_W = 32;
  localparam int GRID_W = 3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int BIT_TIME_NS = 160;
  localparam int BIT_CYC = (BIT_TIME_NS * CLK_MHZ) / 1000;
  localparam int SLOTS_PER_GRID = 1024;
  localparam logic [DIM_W-1:0] DIM_RESET = 10'h000;
  localparam logic [SEG_W-1:0] SEG_RESET = 32'h0000_0000;
  localparam logic [GRID_W-1:0] GRID_IDLE = 3'h7;
  localparam logic [1:0] GRID_LAST_DUP = 2'h1;
  localparam logic [1:0] GRID_LAST_TRI = 2'h2;
  // Word layout: bits 47:38 dimming, 37:34 unused, 33:32 grid select, 31:0 segment data for the selected grid slot.
  localparam int DIM_LSB = 38;
  localparam int GSEL_LSB = 32;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic sdata;
  } vsd_serial_s;

  typedef struct packed {
    logic dim;
    logic sync1;
    logic sync2;
  } vsd_sync_s;
endpackage : vsd_pkg

/* File: logic/vsd_core.sv */
// Serial input, duty and role selection, dimming and frame sync logic.
`timescale 1ns/1ns
// Contract
// - Ignore clock and data while select low.
// - Shift one bit per shift clock rise.
// - Data line high means bit one.
// - Duty select high gives two grids.
// - Duty select low gives three grids.
// - Role select high master, low slave.
// - Slave gates segments with dimming input.
// - Master uses internal 10-bit dimming generator.
// - Slave takes frame timing from sync inputs.
// - Drive dimming output with active pulse: own in master, input in slave.
// - Drive two sync outputs with frame timing.
// - Data counts between select rise and fall.
// - Reset clears state, segments low, grids high.
// - Grid outputs active low when scanned.
module vsd_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire vsd_pkg::vsd_serial_s ser_in,
  input wire logic duty_select,
  input wire logic role_select,
  input wire vsd_pkg::vsd_sync_s sync_in,
  output vsd_pkg::vsd_sync_s sync_out,
  output logic [vsd_pkg::SEG_W-1:0] anode_column_out,
  output logic [vsd_pkg::GRID_W-1:0] cathode_row_out
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] meta_r;
  logic [7:0] sync_r;
  logic sclk_d_r;
  logic [7:0] pins;
  assign pins = {ser_in.sel, ser_in.sclk, ser_in.sdata, duty_select, role_select,
                 sync_in.dim, sync_in.sync1, sync_in.sync2};
  // Static mode pins share the synchroniser, so a change takes effect two cycles later.
  always_ff @(posedge clk) begin
    meta_r <= pins;
    sync_r <= meta_r;
    sclk_d_r <= sync_r[6];
  end
  wire sel_s = sync_r[7];
  wire sclk_s = sync_r[6];
  wire data_s = sync_r[5];
  wire duplex = sync_r[4];
  wire master = sync_r[3];
  wire brightness_pulse_in_s = sync_r[2];
  wire sy1_s = sync_r[1];
  wire sy2_s = sync_r[0];

  // ----------------------------------------
  // Serial shift and latch
  // ----------------------------------------
  logic [vsd_pkg::SHIFT_W-1:0] shift_r;
  logic [5:0] bits_r;
  logic sel_d_r;
  logic [vsd_pkg::SEG_W-1:0] seg_lat_r [3];
  logic [vsd_pkg::DIM_W-1:0] dim_duty_r;
  wire sclk_rise = sclk_s && !sclk_d_r;
  wire shift_en = sel_s && sclk_rise;
  wire frame_end = sel_d_r && !sel_s;
  wire word_full = bits_r == 6'(vsd_pkg::SHIFT_W);
  wire [1:0] gsel = shift_r[vsd_pkg::GSEL_LSB +: 2];
  // Short frames are dropped so a glitch cannot corrupt the latches; an overlong frame latches its last 48 bits.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= '0;
      bits_r <= '0;
      sel_d_r <= 1'b0;
      dim_duty_r <= vsd_pkg::DIM_RESET;
      for (int i = 0; i < 3; i++) begin
        seg_lat_r[i] <= vsd_pkg::SEG_RESET;
      end
    end else begin
      sel_d_r <= sel_s;
      if (sel_s && !sel_d_r) begin
        bits_r <= '0;
      end else if (shift_en) begin
        shift_r <= {shift_r[vsd_pkg::SHIFT_W-2:0], data_s};
        if (!word_full) begin
          bits_r <= bits_r + 6'h01;
        end
      end
      if (frame_end && word_full && gsel != 2'h3) begin
        dim_duty_r <= shift_r[vsd_pkg::DIM_LSB +: vsd_pkg::DIM_W];
        seg_lat_r[gsel] <= shift_r[vsd_pkg::SEG_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Master timebase and dimming
  // ----------------------------------------
  logic [7:0] bit_cnt_r;
  logic [vsd_pkg::DIM_W-1:0] slot_r;
  logic [1:0] grid_r;
  wire bit_tick = bit_cnt_r == 8'(vsd_pkg::BIT_CYC - 1);
  wire [1:0] grid_last = duplex ? vsd_pkg::GRID_LAST_DUP : vsd_pkg::GRID_LAST_TRI;
  wire slot_wrap = bit_tick && slot_r == 10'(vsd_pkg::SLOTS_PER_GRID - 1);
  // The timebase runs in both roles so that a role change never restarts the scan.
  // Slot counting spans the full dimming range, so duty all ones leaves one dark slot.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_r <= '0;
      slot_r <= '0;
      grid_r <= '0;
    end else begin
      bit_cnt_r <= bit_tick ? 8'h00 : bit_cnt_r + 8'h01;
      if (bit_tick) begin
        slot_r <= slot_r + 10'h001;
      end
      if (slot_wrap) begin
        grid_r <= (grid_r >= grid_last) ? 2'h0 : grid_r + 2'h1;
      end
    end
  end
  wire dim_gen = slot_r < dim_duty_r;

  // Sync pair encodes grid index; slave follows it directly, master ignores inputs.
  wire [1:0] grid_act = master ? grid_r : {sy1_s, sy2_s};
  wire dim_act = master ? dim_gen : brightness_pulse_in_s;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic [vsd_pkg::GRID_W-1:0] grid_nxt;
  logic [vsd_pkg::SEG_W-1:0] seg_nxt;
  // In slave role only the segments follow the dimming input; the grid stays on for its slot.
  wire grid_ok = grid_act != 2'h3 && grid_act <= grid_last;
  wire grid_on = grid_ok && (dim_act || !master);
  wire seg_on = grid_ok && dim_act;
  always_comb begin
    grid_nxt = vsd_pkg::GRID_IDLE;
    seg_nxt = vsd_pkg::SEG_RESET;
    if (grid_on) begin
      grid_nxt[grid_act] = 1'b0;
    end
    if (seg_on) begin
      seg_nxt = seg_lat_r[grid_act];
    end
  end
  // Registered outputs keep the pins free of decode glitches.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cathode_row_out <= vsd_pkg::GRID_IDLE;
      anode_column_out <= vsd_pkg::SEG_RESET;
      sync_out <= '0;
    end else begin
      cathode_row_out <= grid_nxt;
      anode_column_out <= seg_nxt;
      sync_out.dim <= dim_act;
      sync_out.sync1 <= grid_act[1];
      sync_out.sync2 <= grid_act[0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ignore_sel_a: assert property (@(posedge clk) disable iff (sys_rst) !sel_s |=> $stable(shift_r))
    else $error("shift register moved with select low");
  shift_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    shift_en |=> shift_r[0] == $past(data_s))
    else $error("shifted bit does not match data line");
  reset_out_a: assert property (@(posedge clk) sys_rst |=> cathode_row_out == vsd_pkg::GRID_IDLE
    && anode_column_out == vsd_pkg::SEG_RESET)
    else $error("outputs not at reset state");
  grid_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    $countones(~cathode_row_out) <= 1)
    else $error("more than one grid active");
  duplex_grid_a: assert property (@(posedge clk) disable iff (sys_rst)
    duplex && master |-> grid_r != 2'h2)
    else $error("third grid used in duplex");
  triplex_grid_a: assert property (@(posedge clk) disable iff (sys_rst)
    grid_r != 2'h3)
    else $error("grid index out of range");
  slave_dim_a: assert property (@(posedge clk) disable iff (sys_rst)
    !master |=> sync_out.dim == $past(brightness_pulse_in_s))
    else $error("slave dimming does not follow input");
  master_dim_a: assert property (@(posedge clk) disable iff (sys_rst)
    master |=> sync_out.dim == $past(dim_gen))
    else $error("master dimming not from generator");
  sync_out_a: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> {sync_out.sync1, sync_out.sync2} == $past(grid_act))
    else $error("sync outputs do not carry frame timing");
  latch_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
    !frame_end |=> $stable(dim_duty_r))
    else $error("dimming latched outside a frame end");
  // A short frame still moves the shift register but never reaches the latches.
  drop_short_a: assert property (@(posedge clk) disable iff (sys_rst)
    frame_end && !word_full |=> $stable(dim_duty_r))
    else $error("short frame reached the dimming latch");
  latch_seg_a: assert property (@(posedge clk) disable iff (sys_rst) frame_end && word_full && gsel != 2'h3
    |=> seg_lat_r[$past(gsel)] == $past(shift_r[vsd_pkg::SEG_W-1:0]))
    else $error("segment word not latched at frame end");
  reset_sync_a: assert property (@(posedge clk) sys_rst |=> sync_out == '0)
    else $error("sync outputs not cleared by reset");
  seg_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    !dim_act |=> anode_column_out == vsd_pkg::SEG_RESET)
    else $error("segments lit outside the dimming pulse");
  // Grid index three is not a scan slot; it blanks the display.
  grid_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    !grid_ok |=> cathode_row_out == vsd_pkg::GRID_IDLE)
    else $error("grid driven for an invalid index");
  slave_grid_a: assert property (@(posedge clk) disable iff (sys_rst)
    !master && grid_ok |=> cathode_row_out[$past(grid_act)] == 1'b0)
    else $error("slave grid not held for its slot");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cov_word: cover property (@(posedge clk) frame_end && word_full);
  cov_slave: cover property (@(posedge clk) !master && !cathode_row_out[0]);
  cov_wrap: cover property (@(posedge clk) slot_wrap && !duplex);
  cov_short: cover property (@(posedge clk) frame_end && !word_full);
  cov_blank: cover property (@(posedge clk) !master && !grid_ok);
endmodule : vsd_core

/* File: bench/vsd_host.sv */
// Host model that drives three-wire serial frames into the display block.
`timescale 1ns/1ns
module vsd_host (
  output vsd_pkg::vsd_serial_s ser
);
  // ------
  // Frames
  // ------
  initial ser = '{sel: 1'b0, sclk: 1'b0, sdata: 1'b1};
  // The shift clock stands still between frames, and released data is flipped so no stale bit lingers.
  task automatic frame(input logic [47:0] w, input int n, input logic en);
    ser.sel = en;
    #400;
    for (int i = 47; i > 47 - n; i--) begin
      ser.sdata = w[i];
      #160 ser.sclk = 1'b1;
      #160 ser.sclk = 1'b0;
    end
    #400 ser.sel = 1'b0;
    ser.sdata = ~ser.sdata;
    #800;
  endtask : frame
endmodule : vsd_host

/* File: bench/test_vfd_serial_input_and_sync.sv */
// Self-checking testbench for the serial input and sync block.
`timescale 1ns/1ns
module test_vfd_serial_input_and_sync;
  // -----
  // Setup
  // -----
  logic clk = 0, sys_rst = 1, duty_select = 1, role_select = 1;
  vsd_pkg::vsd_serial_s ser;
  vsd_pkg::vsd_sync_s sync_in = '0;
  vsd_pkg::vsd_sync_s sync_out;
  logic [31:0] anode_column_out;
  logic [31:0] seg_m [3];
  logic [2:0] cathode_row_out;
  int miscompares = 0, num_checks = 0, seed = 20, cyc = 0, lit = 0, dimc = 0, g;
  bit mon = 0;
  bit seen [3];
  always #20 clk = ~clk;
  vsd_host host_u (.ser(ser));
  vsd_core dut_u (.clk(clk), .sys_rst(sys_rst), .ser_in(ser), .duty_select(duty_select),
    .role_select(role_select), .sync_in(sync_in), .sync_out(sync_out),
    .anode_column_out(anode_column_out), .cathode_row_out(cathode_row_out));
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // Every scanned cycle in a run checks grid and sync; lit segments are compared with the model of the latched words.
  always @(negedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_of_test;
    end
    if (mon && cathode_row_out !== 3'h7) begin
      g = (cathode_row_out === 3'h6) ? 0 : (cathode_row_out === 3'h5) ? 1 : 2;
      check("grid", $countones(~cathode_row_out), 1);
      check("sync", {sync_out.sync1, sync_out.sync2}, g);
      if (anode_column_out !== 0) check("seg", anode_column_out, seg_m[g]);
      seen[g] = 1;
      lit += (anode_column_out !== 0);
      dimc += sync_out.dim;
    end
  end
  task automatic load(input logic [9:0] d);
    for (int k = 0; k < 3; k++) begin
      seg_m[k] = $random(seed);
      host_u.frame({d, 4'h0, 2'(k), seg_m[k]}, 48, 1'b1);
    end
  endtask : load
  task automatic run(input logic dsel, input int n);
    @(posedge clk) #2 duty_select = dsel;
    seen = '{0, 0, 0};
    lit = 0;
    dimc = 0;
    mon = 1;
    repeat (n) @(posedge clk);
    mon = 0;
  endtask : run
  task automatic slave(input logic d, input logic [1:0] i, input logic [2:0] row, input logic [31:0] seg);
    @(posedge clk) #2 sync_in = '{dim: d, sync1: i[1], sync2: i[0]};
    repeat (10) @(posedge clk);
    #2;
    check("srow", cathode_row_out, row);
    check("sseg", anode_column_out, seg);
  endtask : slave
  initial begin
    repeat (10) @(posedge clk);
    #2;
    check("rrow", cathode_row_out, 3'h7);
    check("rseg", anode_column_out, 0);
    sys_rst = 0;
    load(10'h3FF);
    host_u.frame(48'hFFC0_FFFF_FFFF, 48, 1'b0);
    host_u.frame(48'hFFC0_FFFF_FFFF, 47, 1'b1);
    @(posedge clk) #2 sync_in = '1;
    run(1'b1, 13000);
    check("duplex", {seen[0], seen[1], seen[2]}, 3'h6);
    check("lit", lit > 0 && dimc > 0, 1);
    run(1'b0, 13000);
    check("triplex", {seen[0], seen[1], seen[2]}, 3'h7);
    load(10'h000);
    run(1'b0, 5000);
    check("dark", lit, 0);
    load(10'h3FF);
    @(posedge clk) #2 role_select = 0;
    slave(1'b1, 2'h1, 3'h5, seg_m[1]);
    slave(1'b0, 2'h1, 3'h5, 0);
    slave(1'b1, 2'h3, 3'h7, 0);
    end_of_test;
  end
endmodule : test_vfd_serial_input_and_sync
